// [logic/fieldbus_params.svh]
// Constants shared by both ends of the fieldbus command channel
`ifndef FIELDBUS_PARAMS_SVH
`define FIELDBUS_PARAMS_SVH

// Frame lengths in bytes
`define CMD_FRAME_BYTES 8
`define RSP_FRAME_BYTES 22
// Byte offsets inside the frame sent to the indicator
`define CMD_OFS_FORCE 0
`define CMD_OFS_CODE 2
`define CMD_OFS_ARG 4
// Byte offsets inside the frame sent by the indicator
`define RSP_OFS_LIFE 0
`define RSP_OFS_IO 1
`define RSP_OFS_STATUS 2
`define RSP_OFS_RESULT 4
`define RSP_OFS_GROSS 8
`define RSP_OFS_TARE 12
`define RSP_OFS_NET 16
`define RSP_OFS_CHAN 20

// Command codes
`define CMD_NONE 16'h0000
`define CMD_ZERO 16'h0001
`define CMD_TARE_SEMI 16'h0002
`define CMD_TARE_PROG 16'h0003
`define CMD_TARE_CLEAR 16'h0004
`define CMD_REC_STORE 16'h0005
`define CMD_REC_READ 16'h0006
`define CMD_THR1_WR 16'h0015
`define CMD_THR3_WR 16'h0017
`define CMD_THR1_RD 16'h0019
`define CMD_THR3_RD 16'h001B
`define CMD_HYST_RD 16'h001C

// Status codes
`define STATUS_NONE 16'h0000
`define STATUS_DONE_OK 16'h0001
`define STATUS_DONE_FAIL 16'h0002
`define STATUS_IN_PROGRESS 16'h0003

// Channel state bit positions
`define CH_DP_LSB 8
`define CH_STABLE 10
`define CH_ZERO 11
`define CH_OVER 12
`define CH_UNDER 13
`define CH_ADC 14
`define CH_ONE 15

// Off-scale margin in scale divisions
`define OFF_SCALE_DIVS 32'sh9

// Timing
`define CLK_HZ 10000000
`define FREEZE_TIME_MS 1000
`define FREEZE_CYCLES (`FREEZE_TIME_MS * (`CLK_HZ / 1000))
`define STABLE_WAIT_MS 2000
`define STABLE_WAIT_CYCLES (`STABLE_WAIT_MS * (`CLK_HZ / 1000))
`define RSP_PERIOD_US 1000
`define RSP_PERIOD_CYCLES (`RSP_PERIOD_US * (`CLK_HZ / 1000000))
`define CMD_PERIOD_US 1000
`define CMD_PERIOD_CYCLES (`CMD_PERIOD_US * (`CLK_HZ / 1000000))

`endif

// [logic/fieldbus_pkg.sv]
// Types shared by both ends of the fieldbus command channel
package fieldbus_pkg;
  // Indicator command engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT_STABLE = 3'b100
  } dev_state_t;
  // Controller sequencing states
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_CLEAR = 3'b010,
    H_SEND = 3'b100
  } host_state_t;
  typedef logic [31:0] word_t;
  typedef logic [15:0] half_t;
endpackage

// [logic/fieldbus_link_if.sv]
// Byte-serial link between controller and indicator, one modport per end
interface fieldbus_link_if;
  logic cmd_valid;        // Byte of controller frame present
  logic cmd_first;        // Byte is frame byte 0
  logic [7:0] cmd_byte;   // Controller frame byte
  logic rsp_valid;        // Byte of indicator frame present
  logic rsp_first;        // Byte is frame byte 0
  logic [7:0] rsp_byte;   // Indicator frame byte
  modport device (input cmd_valid, cmd_first, cmd_byte,
                  output rsp_valid, rsp_first, rsp_byte);
  modport controller (output cmd_valid, cmd_first, cmd_byte,
                      input rsp_valid, rsp_first, rsp_byte);
endinterface

// [logic/byte_serializer.sv]
// Sends a frame one byte per cycle, most significant byte first
module byte_serializer #(
  parameter int NBYTES = 8
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic START,
  input wire logic [NBYTES*8-1:0] FRAME,
  output logic BUSY,
  output logic TX_VALID,
  output logic TX_FIRST,
  output logic [7:0] TX_BYTE
);
  // All state of the serializer
  typedef struct packed {
    logic [NBYTES*8-1:0] shift;  // Bytes still to go, next at the top
    logic [7:0] left;            // Bytes still to go
    logic valid;                 // Byte on the link
    logic first;                 // Byte 0 of the frame
    logic [7:0] data;            // Byte on the link
  } ser_t;
  ser_t s_reg;
  ser_t s_next;

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    s_next.first = 1'b0;
    if (!RST_B) begin
      s_next = '0;
    end else if (s_reg.left != 8'h00) begin
      // Emit top byte and shift up
      s_next.data = s_reg.shift[NBYTES*8-1 -: 8];
      s_next.valid = 1'b1;
      s_next.first = (s_reg.left == 8'(NBYTES));
      s_next.shift = s_reg.shift << 8;
      s_next.left = s_reg.left - 8'h01;
    end else if (START) begin
      // Take a new frame only when idle
      s_next.shift = FRAME;
      s_next.left = 8'(NBYTES);
    end
  end

  // State register
  always_ff @(posedge CORE_CLK) begin
    s_reg <= s_next;
  end

  assign BUSY = (s_reg.left != 8'h00);
  assign TX_VALID = s_reg.valid;
  assign TX_FIRST = s_reg.first;
  assign TX_BYTE = s_reg.data;
endmodule

// [logic/indicator_cmd.sv]
// Indicator end: decodes controller frames, runs commands, sends results
// Contract
// - Controller writes code and argument to launch.
// - Status and result returned in outgoing frame.
// - Status codes: none, ok, fail, executing.
// - Code 2 tares the present weight.
// - Code 3 loads tare from argument.
// - Programmable tare taken straight from argument.
// - Code 5 stores record, freezes weights 1s.
// - Code 6 returns record number, no store.
// - Codes 21 to 23 write thresholds.
// - Code 0x15 writes threshold 1 raw.
// - Codes 25 to 27 read thresholds.
// - Code 28 reads hysteresis.
// - Multi-byte fields travel MSB first.
// - Raw values scaled by decimal digit count. Code does not scale them; it only reports the count in channel state bits 9:8.
// - Flag weight over range plus 9 divisions.
// - Flag weight under minus 9 divisions.
// - Flag parameter memory checksum failure.
// - Refuse record when stream link congested.
// - Command frame 8 bytes: force, code, arg.
// - Response frame 22 bytes: status, result at 2,4.
// - Code 0 means none, reinitialises channel.
`include "fieldbus_params.svh"
module indicator_cmd #(
  parameter int FREEZE_CYC = `FREEZE_CYCLES,
  parameter int STABLE_WAIT_CYC = `STABLE_WAIT_CYCLES,
  parameter int RSP_PERIOD_CYC = `RSP_PERIOD_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  fieldbus_link_if.device LINK,
  input wire fieldbus_pkg::word_t WEIGHT_RAW,
  input wire fieldbus_pkg::word_t MAX_RANGE,
  input wire fieldbus_pkg::word_t SCALE_DIV,
  input wire fieldbus_pkg::word_t HYSTERESIS,
  input wire logic [1:0] DEC_DIGITS,
  input wire logic STABLE,
  input wire logic ADC_RANGE_ERR,
  input wire logic NVM_CRC_FAIL,
  input wire logic STREAM_BACKLOG,
  input wire logic [3:0] INPUTS_IN,
  output logic [3:0] FORCE_OUT,
  output logic RECORD_STROBE,
  output fieldbus_pkg::word_t RECORD_NO,
  output logic ERR_OVERSCALE,
  output logic ERR_UNDERSCALE,
  output logic PARAM_MEMORY_CHECKSUM_ERROR,
  output logic ERR_STREAM_CONGESTED
);
  import fieldbus_pkg::*;

  localparam int CB = `CMD_FRAME_BYTES;
  localparam int RB = `RSP_FRAME_BYTES;

  // All state of the indicator end
  typedef struct packed {
    dev_state_t state;          // Command engine state
    logic [CB*8-1:0] rx_shift;  // Incoming frame assembly
    logic [3:0] rx_cnt;         // Bytes assembled
    half_t code_prev;           // Code of the last completed frame
    half_t code;                // Command being run
    word_t arg;                 // Its argument
    logic [3:0] force_bits;     // Output forcing
    half_t status;              // Reported status
    word_t result;              // Reported result
    word_t zero_ofs;            // Zero offset
    word_t tare;                // Tare value
    logic [2:0][31:0] thr;      // Thresholds 3..1
    word_t rec_no;              // Record store number
    logic [23:0] frz_cnt;       // Freeze time left
    word_t frz_gross;           // Frozen gross
    word_t frz_tare;            // Frozen tare
    word_t frz_net;             // Frozen net
    logic [31:0] wait_cnt;      // Stability wait left, holds 2 s at 10 MHz
    logic [7:0] life;           // Life counter
    logic [15:0] tx_tmr;        // Cycles to next response frame
    logic tx_start;             // Launch response frame
    logic rec_strobe;           // Print and store pulse
    logic err_over;             // Off-scale overflow
    logic err_under;            // Off-scale underflow
    logic err_nvm;              // Checksum failure
    logic err_stream;           // Record refused, link congested
  } dev_t;
  dev_t s_reg;
  dev_t s_next;

  word_t gross;                 // Live gross weight
  word_t net;                   // Live net weight
  word_t over_lim;              // Overflow limit
  word_t under_lim;             // Underflow limit
  word_t rpt_gross;             // Reported gross
  word_t rpt_tare;              // Reported tare
  word_t rpt_net;               // Reported net
  half_t chan;                  // Channel state word
  half_t rx_code;               // Code of a just-completed frame
  logic [RB*8-1:0] rsp_frame;   // Outgoing frame image
  logic tx_busy;                // Serializer busy
  logic [3:0] rx_cnt_n;         // Byte count after this byte
  logic [CB*8-1:0] rx_shift_n;  // Assembly after this byte

  // Weights, off-scale limits and channel state
  always_comb begin
    gross = WEIGHT_RAW - s_reg.zero_ofs;
    net = gross - s_reg.tare;
    over_lim = MAX_RANGE + `OFF_SCALE_DIVS * SCALE_DIV;
    under_lim = -(`OFF_SCALE_DIVS * SCALE_DIV);
    // Hold reported weights during the freeze window
    rpt_gross = (s_reg.frz_cnt != 24'h0) ? s_reg.frz_gross : gross;
    rpt_tare = (s_reg.frz_cnt != 24'h0) ? s_reg.frz_tare : s_reg.tare;
    rpt_net = (s_reg.frz_cnt != 24'h0) ? s_reg.frz_net : net;
    chan = 16'h0000;
    chan[`CH_DP_LSB +: 2] = DEC_DIGITS;
    chan[`CH_STABLE] = STABLE;
    chan[`CH_ZERO] = (gross == 32'h0);
    chan[`CH_OVER] = s_reg.err_over;
    chan[`CH_UNDER] = s_reg.err_under;
    chan[`CH_ADC] = ADC_RANGE_ERR;
    chan[`CH_ONE] = 1'b1;
    // Frame image, byte 0 at the top so it leaves first
    rsp_frame = {s_reg.life, s_reg.force_bits, INPUTS_IN, s_reg.status,
      s_reg.result, rpt_gross, rpt_tare, rpt_net, chan};
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.rec_strobe = 1'b0;
    s_next.tx_start = 1'b0;
    rx_code = `CMD_NONE;
    rx_cnt_n = LINK.cmd_first ? 4'h1 : s_reg.rx_cnt + 4'h1;
    rx_shift_n = {s_reg.rx_shift[CB*8-9:0], LINK.cmd_byte};
    // Off-scale flags follow the live weight, checksum flag follows its input
    s_next.err_over = $signed(gross) > $signed(over_lim);
    s_next.err_under = $signed(gross) < $signed(under_lim);
    s_next.err_nvm = NVM_CRC_FAIL;
    if (s_reg.frz_cnt != 24'h0) begin
      s_next.frz_cnt = s_reg.frz_cnt - 24'h1;
    end
    // Periodic response frame
    if (s_reg.tx_tmr != 16'h0) begin
      s_next.tx_tmr = s_reg.tx_tmr - 16'h1;
    end else if (!tx_busy) begin
      s_next.tx_tmr = 16'(RSP_PERIOD_CYC - 1);
      s_next.tx_start = 1'b1;
      s_next.life = s_reg.life + 8'h01;
    end
    // Assemble incoming frame
    if (LINK.cmd_valid) begin
      s_next.rx_cnt = rx_cnt_n;
      s_next.rx_shift = rx_shift_n;
      if (rx_cnt_n == 4'(CB)) begin
        rx_code = rx_shift_n[(CB-`CMD_OFS_CODE)*8-1 -: 16];
        s_next.force_bits = rx_shift_n[(CB-`CMD_OFS_FORCE)*8-13 -: 4];
        s_next.code_prev = rx_code;
        if (rx_code == `CMD_NONE) begin
          // Idle code reinitialises the channel once a command ends
          if (s_reg.state == ST_IDLE) begin
            s_next.status = `STATUS_NONE;
          end
        end else if (s_reg.code_prev == `CMD_NONE &&
                     s_reg.state == ST_IDLE) begin
          s_next.code = rx_code;
          s_next.arg = rx_shift_n[(CB-`CMD_OFS_ARG)*8-1 -: 32];
          s_next.status = `STATUS_IN_PROGRESS;
          s_next.state = ST_EXEC;
        end
      end
    end
    // Command engine
    unique case (s_reg.state)
      ST_IDLE: begin
      end
      ST_EXEC: begin
        s_next.state = ST_IDLE;
        s_next.status = `STATUS_DONE_OK;
        s_next.result = 32'h0;
        if (s_reg.code == `CMD_ZERO) begin
          s_next.zero_ofs = WEIGHT_RAW;
        end else if (s_reg.code == `CMD_TARE_SEMI) begin
          // Wait for a stable weight before taring
          s_next.status = `STATUS_IN_PROGRESS;
          s_next.wait_cnt = 32'(STABLE_WAIT_CYC);
          s_next.state = ST_WAIT_STABLE;
        end else if (s_reg.code == `CMD_TARE_PROG) begin
          s_next.tare = s_reg.arg;
        end else if (s_reg.code == `CMD_TARE_CLEAR) begin
          s_next.tare = 32'h0;
        end else if (s_reg.code == `CMD_REC_STORE) begin
          if (STREAM_BACKLOG) begin
            s_next.status = `STATUS_DONE_FAIL;
            s_next.err_stream = 1'b1;
          end else begin
            s_next.rec_no = s_reg.rec_no + 32'h1;
            s_next.result = s_reg.rec_no + 32'h1;
            s_next.rec_strobe = 1'b1;
            s_next.err_stream = 1'b0;
            s_next.frz_gross = gross;
            s_next.frz_tare = s_reg.tare;
            s_next.frz_net = net;
            s_next.frz_cnt = 24'(FREEZE_CYC);
          end
        end else if (s_reg.code == `CMD_REC_READ) begin
          s_next.result = s_reg.rec_no;
        end else if (s_reg.code >= `CMD_THR1_WR &&
                     s_reg.code <= `CMD_THR3_WR) begin
          s_next.thr[2'(s_reg.code - `CMD_THR1_WR)] = s_reg.arg;
        end else if (s_reg.code >= `CMD_THR1_RD &&
                     s_reg.code <= `CMD_THR3_RD) begin
          s_next.result = s_reg.thr[2'(s_reg.code - `CMD_THR1_RD)];
        end else if (s_reg.code == `CMD_HYST_RD) begin
          s_next.result = HYSTERESIS;
        end else begin
          // Unknown code
          s_next.status = `STATUS_DONE_FAIL;
        end
      end
      ST_WAIT_STABLE: begin
        if (STABLE) begin
          s_next.tare = gross;
          s_next.status = `STATUS_DONE_OK;
          s_next.state = ST_IDLE;
        end else if (s_reg.wait_cnt == 32'h0) begin
          s_next.status = `STATUS_DONE_FAIL;
          s_next.state = ST_IDLE;
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt - 32'h1;
        end
      end
    endcase
    // Synchronous reset
    if (!RST_B) begin
      s_next = '0;
      s_next.state = ST_IDLE;
    end
  end

  // State register
  always_ff @(posedge CORE_CLK) begin
    s_reg <= s_next;
  end

  // Response frame serializer
  byte_serializer #(.NBYTES(RB)) u_rsp_ser (
    .CORE_CLK(CORE_CLK),
    .RST_B(RST_B),
    .START(s_reg.tx_start),
    .FRAME(rsp_frame),
    .BUSY(tx_busy),
    .TX_VALID(LINK.rsp_valid),
    .TX_FIRST(LINK.rsp_first),
    .TX_BYTE(LINK.rsp_byte)
  );

  assign FORCE_OUT = s_reg.force_bits;
  assign RECORD_STROBE = s_reg.rec_strobe;
  assign RECORD_NO = s_reg.rec_no;
  assign ERR_OVERSCALE = s_reg.err_over;
  assign ERR_UNDERSCALE = s_reg.err_under;
  assign PARAM_MEMORY_CHECKSUM_ERROR = s_reg.err_nvm;
  assign ERR_STREAM_CONGESTED = s_reg.err_stream;
endmodule

// [logic/controller_cmd.sv]
// Controller end: sequences one command through the indicator
`include "fieldbus_params.svh"
module controller_cmd #(
  parameter int CMD_PERIOD_CYC = `CMD_PERIOD_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  fieldbus_link_if.controller LINK,
  input wire logic CMD_REQ,
  input wire fieldbus_pkg::half_t CMD_CODE,
  input wire fieldbus_pkg::word_t CMD_ARG,
  input wire logic [3:0] FORCE_IN,
  output logic CMD_BUSY,
  output logic CMD_DONE,
  output logic CMD_OK,
  output fieldbus_pkg::word_t CMD_RESULT,
  output fieldbus_pkg::word_t GROSS,
  output fieldbus_pkg::word_t NET,
  output fieldbus_pkg::half_t CHAN_STATE
);
  import fieldbus_pkg::*;

  localparam int CB = `CMD_FRAME_BYTES;
  localparam int RB = `RSP_FRAME_BYTES;

  // All state of the controller end
  typedef struct packed {
    host_state_t state;         // Sequencing state
    half_t code;                // Command to send
    word_t arg;                 // Its argument
    logic [3:0] force_bits;     // Forcing to send
    logic [RB*8-1:0] rx_shift;  // Response frame assembly
    logic [4:0] rx_cnt;         // Bytes assembled
    logic [15:0] tx_tmr;        // Cycles to next frame
    logic tx_start;             // Launch command frame
    logic done;                 // Completion pulse
    logic ok;                   // Last command succeeded
    word_t result;              // Last result
    word_t gross;               // Gross weight seen
    word_t net;                 // Net weight seen
    half_t chan;                // Channel state seen
  } host_t;
  host_t s_reg;
  host_t s_next;

  logic [4:0] rx_cnt_n;          // Byte count after this byte
  logic [RB*8-1:0] rx_shift_n;   // Assembly after this byte
  half_t rx_status;              // Status of a completed frame
  logic [CB*8-1:0] cmd_frame;    // Outgoing frame image
  logic tx_busy;                 // Serializer busy

  // Send the idle code except while a command is being launched
  always_comb begin
    cmd_frame = {12'h000, s_reg.force_bits,
      (s_reg.state == H_SEND) ? s_reg.code : `CMD_NONE,
      s_reg.arg};
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.tx_start = 1'b0;
    rx_status = `STATUS_NONE;
    rx_cnt_n = LINK.rsp_first ? 5'h01 : s_reg.rx_cnt + 5'h01;
    rx_shift_n = {s_reg.rx_shift[RB*8-9:0], LINK.rsp_byte};
    // Periodic command frame
    if (s_reg.tx_tmr != 16'h0) begin
      s_next.tx_tmr = s_reg.tx_tmr - 16'h1;
    end else if (!tx_busy) begin
      s_next.tx_tmr = 16'(CMD_PERIOD_CYC - 1);
      s_next.tx_start = 1'b1;
    end
    // Accept a new request when idle
    if (s_reg.state == H_IDLE && CMD_REQ) begin
      s_next.code = CMD_CODE;
      s_next.arg = CMD_ARG;
      s_next.force_bits = FORCE_IN;
      s_next.state = H_CLEAR;
    end
    // Response frame assembly
    if (LINK.rsp_valid) begin
      s_next.rx_cnt = rx_cnt_n;
      s_next.rx_shift = rx_shift_n;
      if (rx_cnt_n == 5'(RB)) begin
        rx_status = rx_shift_n[(RB-`RSP_OFS_STATUS)*8-1 -: 16];
        s_next.gross = rx_shift_n[(RB-`RSP_OFS_GROSS)*8-1 -: 32];
        s_next.net = rx_shift_n[(RB-`RSP_OFS_NET)*8-1 -: 32];
        s_next.chan = rx_shift_n[(RB-`RSP_OFS_CHAN)*8-1 -: 16];
        unique case (s_reg.state)
          H_IDLE: begin
          end
          H_CLEAR: begin
            // Channel back to none before a new code
            if (rx_status == `STATUS_NONE) begin
              s_next.state = H_SEND;
            end
          end
          H_SEND: begin
            // Wait for ok or fail before taking the result
            if (rx_status == `STATUS_DONE_OK ||
                rx_status == `STATUS_DONE_FAIL) begin
              s_next.ok = (rx_status == `STATUS_DONE_OK);
              s_next.result = rx_shift_n[(RB-`RSP_OFS_RESULT)*8-1 -: 32];
              s_next.done = 1'b1;
              s_next.state = H_IDLE;
            end
          end
        endcase
      end
    end
    // Synchronous reset
    if (!RST_B) begin
      s_next = '0;
      s_next.state = H_IDLE;
    end
  end

  // State register
  always_ff @(posedge CORE_CLK) begin
    s_reg <= s_next;
  end

  // Command frame serializer
  byte_serializer #(.NBYTES(CB)) u_cmd_ser (
    .CORE_CLK(CORE_CLK),
    .RST_B(RST_B),
    .START(s_reg.tx_start),
    .FRAME(cmd_frame),
    .BUSY(tx_busy),
    .TX_VALID(LINK.cmd_valid),
    .TX_FIRST(LINK.cmd_first),
    .TX_BYTE(LINK.cmd_byte)
  );

  assign CMD_BUSY = (s_reg.state != H_IDLE);
  assign CMD_DONE = s_reg.done;
  assign CMD_OK = s_reg.ok;
  assign CMD_RESULT = s_reg.result;
  assign GROSS = s_reg.gross;
  assign NET = s_reg.net;
  assign CHAN_STATE = s_reg.chan;
endmodule

// [verification/fieldbus_link_sva.sv]
// Checker for the byte link between controller and indicator
module fieldbus_link_sva (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic cmd_valid,
  input wire logic cmd_first,
  input wire logic [7:0] cmd_byte,
  input wire logic rsp_valid,
  input wire logic rsp_first,
  input wire logic [7:0] rsp_byte
);
  logic [4:0] rcnt_reg; // Index of the next indicator frame byte
  // Counts indicator frame bytes from the first-byte marker
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) rcnt_reg <= 5'h00;
    else if (rsp_first) rcnt_reg <= 5'h01;
    else if (rsp_valid) rcnt_reg <= rcnt_reg + 5'h01;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  AST_CMD_FIRST: assert property (cmd_first |-> cmd_valid)
    else $error("command first byte without valid");
  AST_CMD_LEN: assert property (
    cmd_first |-> cmd_valid [*8] ##1 !cmd_valid)
    else $error("command frame is not eight bytes");
  AST_CMD_ONE_FIRST: assert property (cmd_first |=> !cmd_first [*7])
    else $error("first marker repeated inside a frame");
  AST_FORCE_UNUSED: assert property (
    cmd_first |-> cmd_byte == 8'h00 ##1 cmd_byte[7:4] == 4'h0)
    else $error("unused forcing bits not zero");
  AST_RSP_FIRST: assert property (rsp_first |-> rsp_valid)
    else $error("response first byte without valid");
  AST_RSP_LEN: assert property ($fell(rsp_valid) |-> rcnt_reg == 5'h16)
    else $error("response frame is not 22 bytes");
  AST_STATUS_CODE: assert property (
    rsp_valid && !rsp_first && rcnt_reg == 5'h02
    |-> rsp_byte == 8'h00 ##1 rsp_byte <= 8'h03)
    else $error("status field out of range");
  AST_CHAN_FIXED: assert property (
    rsp_valid && !rsp_first && rcnt_reg == 5'h14
    |-> rsp_byte[7] ##1 rsp_byte == 8'h00)
    else $error("channel state fixed bits wrong");
  cover property (cmd_first);
  cover property (rsp_first);
  cover property (rsp_valid && rcnt_reg == 5'h15);
endmodule

// [verification/weigh_indicator_fieldbus_cmd_tb.sv]
// Bench joining controller and indicator across the byte link
`include "fieldbus_params.svh"
module weigh_indicator_fieldbus_cmd_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fieldbus_pkg::*;
  logic clk = 1'b0; // Core clock
  logic rst_b = 1'b0; // Reset, active low
  logic req = 1'b0; // Command request
  half_t code = 16'h0000; // Command code
  word_t arg = 32'h00000000; // Command argument
  logic [3:0] force_in = 4'h0; // Forcing bits sent
  word_t weight = 32'h00000000; // Raw weight
  word_t hyst = 32'h00000000; // Hysteresis value
  logic stable = 1'b1; // Weight stable
  logic crc = 1'b0; // Checksum fail
  logic backlog = 1'b0; // Stream link congested
  logic [1:0] dd = 2'h0; // Decimal digits
  logic [3:0] ins = 4'h0; // Input image
  logic adc = 1'b0; // Converter out of range
  word_t max_rng = 32'h000003E8; // Maximum range, raw
  word_t div = 32'h0000000A; // Raw counts per scale division
  logic busy, done, ok, strobe, over, under, crc_err, cong;
  word_t result, gross, net, rec_no;
  half_t chan;
  logic [3:0] force_out;
  int failures = 0, cmp_count = 0, seed = 25467, strobes = 0;
  int zoff = 0; // Model zero offset
  int thr [3]; // Model thresholds
  fieldbus_link_if link ();
  controller_cmd #(.CMD_PERIOD_CYC(40)) i_controller_cmd (.CORE_CLK(clk),
    .RST_B(rst_b), .LINK(link.controller), .CMD_REQ(req), .CMD_CODE(code),
    .CMD_ARG(arg), .FORCE_IN(force_in), .CMD_BUSY(busy), .CMD_DONE(done),
    .CMD_OK(ok), .CMD_RESULT(result), .GROSS(gross), .NET(net),
    .CHAN_STATE(chan));
  indicator_cmd #(.FREEZE_CYC(200), .STABLE_WAIT_CYC(100),
    .RSP_PERIOD_CYC(40)) i_indicator_cmd (.CORE_CLK(clk), .RST_B(rst_b),
    .LINK(link.device), .WEIGHT_RAW(weight), .MAX_RANGE(max_rng),
    .SCALE_DIV(div), .HYSTERESIS(hyst), .DEC_DIGITS(dd),
    .STABLE(stable), .ADC_RANGE_ERR(adc), .NVM_CRC_FAIL(crc),
    .STREAM_BACKLOG(backlog), .INPUTS_IN(ins), .FORCE_OUT(force_out),
    .RECORD_STROBE(strobe), .RECORD_NO(rec_no), .ERR_OVERSCALE(over),
    .ERR_UNDERSCALE(under), .PARAM_MEMORY_CHECKSUM_ERROR(crc_err),
    .ERR_STREAM_CONGESTED(cong));
  fieldbus_link_sva i_fieldbus_link_sva (.CORE_CLK(clk), .RST_B(rst_b),
    .cmd_valid(link.cmd_valid), .cmd_first(link.cmd_first),
    .cmd_byte(link.cmd_byte), .rsp_valid(link.rsp_valid),
    .rsp_first(link.rsp_first), .rsp_byte(link.rsp_byte));
  // Clock at 100 ns period
  always #50 clk = ~clk;
  // Counts stored records
  always @(negedge clk) if (strobe === 1'b1) strobes++;
  // Verdict and end of run
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Word compare
  task automatic cmp_w(input word_t got, input word_t exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Flag compare
  task automatic cmp_b(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One command through the controller, checked against the model
  task automatic run(input half_t c, input word_t a, input logic eok,
                     input word_t eres);
    int n;
    code = c;
    arg = a;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    cmp_b(busy, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 800) begin
      @(negedge clk);
      n++;
    end
    if (n >= 800) failures++;
    cmp_b(ok, eok);
    cmp_w(result, eres);
    cmp_b(busy, 1'b0);
    $display("test %h done", c);
  endtask
  // Off-scale flags at a weight relative to the zero offset
  task automatic flag(input int d, input logic eo, input logic eu);
    weight = zoff + d;
    repeat (3) @(negedge clk);
    cmp_b(over, eo);
    cmp_b(under, eu);
  endtask
  // Watchdog
  initial begin
    #2000000;
    failures++;
    end_of_test;
  end
  // Main sequence
  initial begin
    dd = 2'($random(seed));
    ins = 4'($random(seed));
    force_in = 4'($random(seed));
    weight = 32'($random(seed)) & 32'h000001FF;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    run(`CMD_ZERO, 32'h0, 1'b1, 32'h0);
    zoff = weight;
    weight = zoff + 200;
    run(`CMD_TARE_SEMI, 32'h0, 1'b1, 32'h0);
    cmp_w(gross, 32'd200);
    cmp_w(net, 32'h0);
    arg = 32'($random(seed)) & 32'h00000FFF;
    run(`CMD_TARE_PROG, arg, 1'b1, 32'h0);
    cmp_w(net, 32'd200 - arg);
    run(`CMD_TARE_CLEAR, 32'h0, 1'b1, 32'h0);
    cmp_w(net, 32'd200);
    cmp_w({28'h0000000, force_out}, {28'h0000000, force_in});
    thr[0] = 32'h00002134;
    run(`CMD_THR1_WR, 32'h00002134, 1'b1, 32'h0);
    for (int i = 1; i < 3; i++) begin
      thr[i] = $random(seed);
      run(half_t'(16'h0015 + i), thr[i], 1'b1, 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      run(half_t'(16'h0019 + i), 32'h0, 1'b1, thr[i]);
    end
    hyst = $random(seed);
    run(`CMD_HYST_RD, 32'h0, 1'b1, hyst);
    run(`CMD_REC_READ, 32'h0, 1'b1, 32'h0);
    run(`CMD_REC_STORE, 32'h0, 1'b1, 32'h1);
    cmp_w(rec_no, 32'h1);
    cmp_w(strobes, 32'h1);
    weight = zoff + 300;
    repeat (90) @(negedge clk);
    cmp_w(gross, 32'd200);
    repeat (250) @(negedge clk);
    cmp_w(gross, 32'd300);
    backlog = 1'b1;
    run(`CMD_REC_STORE, 32'h0, 1'b0, 32'h0);
    cmp_b(cong, 1'b1);
    backlog = 1'b0;
    run(`CMD_REC_READ, 32'h0, 1'b1, 32'h1);
    run(16'h0007, 32'h0, 1'b0, 32'h0);
    stable = 1'b0;
    run(`CMD_TARE_SEMI, 32'h0, 1'b0, 32'h0);
    stable = 1'b1;
    cmp_w({30'h0, chan[9:8]}, {30'h0, dd});
    flag(1090, 1'b0, 1'b0);
    flag(1091, 1'b1, 1'b0);
    flag(-90, 1'b0, 1'b0);
    flag(-91, 1'b0, 1'b1);
    crc = 1'b1;
    repeat (2) @(negedge clk);
    cmp_b(crc_err, 1'b1);
    adc = 1'b1;
    repeat (80) @(negedge clk);
    cmp_b(chan[14], 1'b1);
    cmp_b(chan[13], 1'b1);
    $display("test flags done");
    end_of_test;
  end
endmodule
